// file: hw/peripheral_disable_write_lock.sv
// module: apb register bank with write-protected peripheral-disable registers
`timescale 1ns/1ps
module peripheral_disable_write_lock (
    input  wire logic         i_clock,                     // 40 mhz peripheral bus clock
    input  wire logic         i_rst,                       // synchronous, active high
    input  wire logic [15:0]  i_paddr,                     // apb byte address
    input  wire logic         i_psel,                      // apb select
    input  wire logic         i_penable,                   // apb access phase
    input  wire logic         i_pwrite,                    // apb direction, high = write
    input  wire logic [31:0]  i_pwdata,                    // apb write data
    input  wire logic [31:0]  i_config_word_three,         // nonvolatile configuration word
    output logic      [31:0]  o_prdata,                    // apb read data
    output logic              o_pready,                    // apb ready
    output logic              o_pslverr,                   // apb error, never raised
    output logic      [127:0] o_peripheral_disable_regs,   // four disable words, lowest first
    output logic              o_peripheral_disable_lock    // current lock bit
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // true when the address falls on a peripheral-disable register
    function automatic logic pmd_hit(input logic [15:0] addr);
        pmd_hit = (addr[15:4] == pmd_lock_pkg::OFS_PMD_BASE[15:4]) && (addr[1:0] == 2'h0);
    endfunction : pmd_hit

    // index of the peripheral-disable register
    function automatic logic [1:0] pmd_idx(input logic [15:0] addr);
        pmd_idx = addr[3:2];
    endfunction : pmd_idx

    // ----------------------------------------------------------------
    // configuration word synchroniser
    // ----------------------------------------------------------------
    logic [31:0] cfg_meta_q;  // first stage, read only by the second
    logic [31:0] cfg_sync_q;  // safe copy of the configuration word

    // two flops for a quasi-static level from outside the clock domain
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            cfg_meta_q <= pmd_lock_pkg::CFG_RESET;
            cfg_sync_q <= pmd_lock_pkg::CFG_RESET;
        end else begin
            cfg_meta_q <= i_config_word_three;
            cfg_sync_q <= cfg_meta_q;
        end
    end

    logic one_way;  // lock_one_way_select
    assign one_way = cfg_sync_q[pmd_lock_pkg::ONE_WAY_BIT];

    // ----------------------------------------------------------------
    // apb handshake
    // ----------------------------------------------------------------
    localparam int unsigned PMD_LOCK_N = pmd_lock_pkg::PMD_COUNT;  // disable words held here

    logic        ready_q;   // ready, high for one access cycle
    logic        ready_d;
    logic [31:0] prdata_q;  // read data held for the master
    logic [31:0] prdata_d;
    logic        err_q;     // slave error flop
    logic        err_d;
    logic        access;    // access phase present
    logic        fire;      // transfer completes at this edge
    logic        fire_wr;   // write completes at this edge
    logic        lock_q;    // peripheral_disable_lock
    logic        lock_d;
    logic [PMD_LOCK_N-1:0][31:0] pmd_q;  // peripheral_disable_regs
    logic [PMD_LOCK_N-1:0][31:0] pmd_d;

    assign access  = i_psel && i_penable;
    assign fire    = access && ready_q;
    assign fire_wr = fire && i_pwrite;

    // read multiplexer; unmapped and write-only addresses read zero
    function automatic logic [31:0] read_mux(input logic [15:0] addr, input logic lock,
                                             input logic [31:0] cfg,
                                             input logic [PMD_LOCK_N-1:0][31:0] pmd);
        read_mux = 32'h0000_0000;
        if (addr == pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL) begin
            read_mux[pmd_lock_pkg::LOCK_BIT] = lock;
        end else if (addr == pmd_lock_pkg::OFS_CONFIG_WORD_THREE) begin
            read_mux = cfg;
        end else if (pmd_hit(addr)) begin
            read_mux = pmd[pmd_idx(addr)];
        end
    endfunction : read_mux

    // one wait state: ready rises in the second access cycle
    always_comb begin
        ready_d  = access && !ready_q;
        prdata_d = prdata_q;
        err_d    = 1'b0;  // every access completes without error
        if (access && !ready_q) begin
            prdata_d = read_mux(i_paddr, lock_q, cfg_sync_q, pmd_q);
        end
    end

    // handshake registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ready_q  <= 1'b0;
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
        end else begin
            ready_q  <= ready_d;
            prdata_q <= prdata_d;
            err_q    <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // unlock sequencer
    // ----------------------------------------------------------------
    unlock_if seq_bus ();

    logic key_wr;  // accepted write to the key register
    assign key_wr           = fire_wr && (i_paddr == pmd_lock_pkg::OFS_SYSTEM_KEY);
    assign seq_bus.key_wr   = key_wr;
    assign seq_bus.other_wr = fire_wr && !key_wr;
    assign seq_bus.wdata    = i_pwdata;
    assign seq_bus.block    = one_way && lock_q;

    unlock_sequencer u_seq (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .bus     (seq_bus)
    );

    // ----------------------------------------------------------------
    // lock bit and protected registers
    // ----------------------------------------------------------------
    logic wr_ctrl;  // accepted write to system_config_control
    assign wr_ctrl = fire_wr && (i_paddr == pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL);

    // next values of the lock and the disable words
    always_comb begin
        lock_d = lock_q;
        pmd_d  = pmd_q;
        if (wr_ctrl && seq_bus.armed) begin
            // only the write right after a full sequence counts
            if (!(one_way && lock_q)) begin
                lock_d = i_pwdata[pmd_lock_pkg::LOCK_BIT];
            end
        end
        if (fire_wr && pmd_hit(i_paddr) && !lock_q) begin
            pmd_d[pmd_idx(i_paddr)] = i_pwdata;  // locked writes are dropped quietly
        end
    end

    // only a reset frees a stuck lock
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lock_q <= pmd_lock_pkg::LOCK_RESET;
            pmd_q  <= {PMD_LOCK_N{pmd_lock_pkg::PMD_RESET}};
        end else begin
            lock_q <= lock_d;
            pmd_q  <= pmd_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_prdata                  = prdata_q;
    assign o_pready                  = ready_q;
    assign o_pslverr                 = err_q;
    assign o_peripheral_disable_regs = pmd_q;
    assign o_peripheral_disable_lock = lock_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    logic       pmd_wr_hit;  // helper: write lands on a disable word
    logic [1:0] pmd_wr_idx;  // helper: its index
    assign pmd_wr_hit = fire_wr && pmd_hit(i_paddr);
    assign pmd_wr_idx = pmd_idx(i_paddr);

    property p_locked_write_no_effect;
        pmd_wr_hit && lock_q |-> !o_pslverr ##1 $stable(pmd_q);
    endproperty
    a_locked_write_no_effect: assert property (p_locked_write_no_effect)
        else $error("locked write changed a disable register or raised an error");

    property p_lock_readback;
        access && !ready_q && !i_pwrite && i_paddr == pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL
            |=> o_pready && o_prdata[pmd_lock_pkg::LOCK_BIT] == $past(lock_q);
    endproperty
    a_lock_readback: assert property (p_lock_readback)
        else $error("control register read does not show the lock");

    property p_unlocked_write_stores;
        pmd_wr_hit && !lock_q |=> pmd_q[$past(pmd_wr_idx)] == $past(i_pwdata);
    endproperty
    a_unlocked_write_stores: assert property (p_unlocked_write_stores)
        else $error("unlocked write to a disable register was lost");

    property p_lock_needs_unlock;
        $changed(lock_q) |-> $past(wr_ctrl) && $past(seq_bus.armed);
    endproperty
    a_lock_needs_unlock: assert property (p_lock_needs_unlock)
        else $error("lock changed without the unlock sequence");

    property p_one_way_sticky;
        one_way && lock_q && $stable(one_way) |=> lock_q;
    endproperty
    a_one_way_sticky: assert property (p_one_way_sticky)
        else $error("one-way lock was cleared");

    property p_one_way_no_arm;
        one_way && lock_q |=> !seq_bus.armed;
    endproperty
    a_one_way_no_arm: assert property (p_one_way_no_arm)
        else $error("unlock sequence ran while one-way locked");

    property p_reset_clears;
        @(posedge i_clock) disable iff (1'b0) i_rst |=> !lock_q && pmd_q == '0;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset did not clear the lock");

    property p_arm_single_use;
        seq_bus.armed && fire_wr |=> !seq_bus.armed;
    endproperty
    a_arm_single_use: assert property (p_arm_single_use)
        else $error("armed state outlived the next write");

    c_lock_set: cover property ($rose(lock_q));
    c_lock_cleared: cover property ($fell(lock_q));
    c_locked_write: cover property (pmd_wr_hit && lock_q);
    c_one_way_stuck: cover property (one_way && lock_q && key_wr);

endmodule : peripheral_disable_write_lock

// file: hw/pmd_lock_pkg.sv
// package: offsets, field positions, reset values and keys for the peripheral-disable write lock
package pmd_lock_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W    = 16;  // byte address width seen by the block
    localparam int unsigned DATA_W    = 32;  // apb data width
    localparam int unsigned PMD_COUNT = 4;   // number of peripheral-disable registers

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] OFS_SYSTEM_CONFIG_CONTROL = 16'h0000;  // lock bit lives here
    localparam logic [15:0] OFS_SYSTEM_KEY            = 16'h0004;  // unlock key writes
    localparam logic [15:0] OFS_PMD_BASE              = 16'h0010;  // first peripheral-disable register
    localparam logic [15:0] OFS_CONFIG_WORD_THREE     = 16'hffc0;  // read-only configuration word

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned LOCK_BIT    = 12;  // peripheral_disable_lock in system_config_control
    localparam int unsigned ONE_WAY_BIT = 28;  // lock_one_way_select in config_word_three

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic        LOCK_RESET = 1'b0;          // writes allowed after reset
    localparam logic [31:0] PMD_RESET  = 32'h0000_0000; // all peripherals enabled
    localparam logic [31:0] CFG_RESET  = 32'h0000_0000; // synchroniser contents at reset

    // ----------------------------------------------------------------
    // unlock keys (values are arbitrary)
    // ----------------------------------------------------------------
    localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'h1357_9bdf;
    localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h2468_ace0;

    // unlock sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_GOT_FIRST,
        SEQ_ARMED
    } unlock_state_e;

endpackage : pmd_lock_pkg

// file: hw/unlock_if.sv
// interface: bus events into the unlock sequencer and its armed flag back
`timescale 1ns/1ps
interface unlock_if;
    logic        key_wr;    // one-cycle: accepted write to the key register
    logic        other_wr;  // one-cycle: accepted write anywhere else
    logic [31:0] wdata;     // data of the key write
    logic        block;     // level: sequence must not run
    logic        armed;     // level: next write may change the lock

    modport seq (input key_wr, input other_wr, input wdata, input block, output armed);
    modport ctl (output key_wr, output other_wr, output wdata, output block, input armed);
endinterface : unlock_if

// file: hw/unlock_sequencer.sv
// module: key sequence tracker that arms a single lock-bit change
`timescale 1ns/1ps
module unlock_sequencer (
    input  wire logic i_clock,  // 40 mhz bus clock
    input  wire logic i_rst,    // synchronous, active high
    unlock_if.seq     bus       // events in, armed out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pmd_lock_pkg::unlock_state_e state_q;  // current step of the sequence
    pmd_lock_pkg::unlock_state_e state_d;  // next step

    // next-state logic: two keys in a row arm, any later write disarms
    always_comb begin
        state_d = state_q;
        if (bus.block) begin
            // one-way lock held: the procedure never executes
            state_d = pmd_lock_pkg::SEQ_IDLE;
        end else begin
            unique case (state_q)
                pmd_lock_pkg::SEQ_IDLE: begin
                    if (bus.key_wr && bus.wdata == pmd_lock_pkg::UNLOCK_KEY_FIRST) begin
                        state_d = pmd_lock_pkg::SEQ_GOT_FIRST;
                    end
                end
                pmd_lock_pkg::SEQ_GOT_FIRST: begin
                    if (bus.key_wr && bus.wdata == pmd_lock_pkg::UNLOCK_KEY_SECOND) begin
                        state_d = pmd_lock_pkg::SEQ_ARMED;
                    end else if (bus.key_wr || bus.other_wr) begin
                        state_d = pmd_lock_pkg::SEQ_IDLE;   // wrong order restarts
                    end
                end
                pmd_lock_pkg::SEQ_ARMED: begin
                    if (bus.key_wr || bus.other_wr) begin
                        state_d = pmd_lock_pkg::SEQ_IDLE;   // only one write may use it
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_q <= pmd_lock_pkg::SEQ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign bus.armed = (state_q == pmd_lock_pkg::SEQ_ARMED);

endmodule : unlock_sequencer

// file: tb/tb_top.sv
// testbench: apb sequences that exercise the peripheral-disable write lock
`timescale 1ns/1ps
module tb_top;

    // ----------------------------------------------------------------
    // signals and counters
    // ----------------------------------------------------------------
    logic         i_clock;                    // 40 mhz bus clock
    logic         i_rst;                      // synchronous reset, active high
    logic [15:0]  i_paddr;                    // apb address
    logic         i_psel;                     // apb select
    logic         i_penable;                  // apb access phase
    logic         i_pwrite;                   // apb direction
    logic [31:0]  i_pwdata;                   // apb write data
    logic [31:0]  i_config_word_three;        // configuration word
    logic [31:0]  o_prdata;                   // apb read data
    logic         o_pready;                   // apb ready
    logic         o_pslverr;                  // apb error
    logic [127:0] o_peripheral_disable_regs;  // disable words
    logic         o_peripheral_disable_lock;  // lock bit
    int           num_errors;                 // mismatches
    int           num_checks;                 // comparisons
    int           cycles;                     // timeout counter
    logic [31:0]  rd;                         // last read data
    logic [31:0]  lk;                         // lock bit in its register position

    // ----------------------------------------------------------------
    // device under test
    // ----------------------------------------------------------------
    peripheral_disable_write_lock u_dut (
        .i_clock                   (i_clock),
        .i_rst                     (i_rst),
        .i_paddr                   (i_paddr),
        .i_psel                    (i_psel),
        .i_penable                 (i_penable),
        .i_pwrite                  (i_pwrite),
        .i_pwdata                  (i_pwdata),
        .i_config_word_three       (i_config_word_three),
        .o_prdata                  (o_prdata),
        .o_pready                  (o_pready),
        .o_pslverr                 (o_pslverr),
        .o_peripheral_disable_regs (o_peripheral_disable_regs),
        .o_peripheral_disable_lock (o_peripheral_disable_lock)
    );

    // clock generator, 25 ns period
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    // ----------------------------------------------------------------
    // helper tasks
    // ----------------------------------------------------------------
    // prints counts and the verdict, then ends the run
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // compares a seen value with the expected one
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge i_clock);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_paddr   <= a;
        i_pwrite  <= w;
        i_pwdata  <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clock);
        end while (o_pready !== 1'b1);
        r = o_prdata;
        check({31'h0, o_pslverr}, 32'h0);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : xfer

    // write shorthand
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask : wr

    // read and compare shorthand
    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, rd);
        check(rd, exp);
    endtask : rd_chk

    // the two key writes that arm one lock change
    task automatic unlock;
        wr(pmd_lock_pkg::OFS_SYSTEM_KEY, pmd_lock_pkg::UNLOCK_KEY_FIRST);
        wr(pmd_lock_pkg::OFS_SYSTEM_KEY, pmd_lock_pkg::UNLOCK_KEY_SECOND);
    endtask : unlock

    // applies reset for two cycles
    task automatic do_reset;
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clock);
    endtask : do_reset

    // cuts a hang short
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_paddr = 16'h0000;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_pwdata = 32'h0;
        i_config_word_three = 32'h0;
        num_errors = 0;
        num_checks = 0;
        cycles = 0;
        lk = 32'h1 << pmd_lock_pkg::LOCK_BIT;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        // reset state and unlocked stores
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        wr(pmd_lock_pkg::OFS_PMD_BASE, 32'ha5a5_0001);
        rd_chk(pmd_lock_pkg::OFS_PMD_BASE, 32'ha5a5_0001);
        rd_chk(16'h0020, 32'h0);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_KEY, 32'h0);
        // lock write without the sequence, and with a broken one
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        wr(pmd_lock_pkg::OFS_SYSTEM_KEY, pmd_lock_pkg::UNLOCK_KEY_FIRST);
        wr(pmd_lock_pkg::OFS_SYSTEM_KEY, 32'h0bad_0bad);
        wr(pmd_lock_pkg::OFS_SYSTEM_KEY, pmd_lock_pkg::UNLOCK_KEY_SECOND);
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        // proper sequence sets the lock
        unlock();
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        @(negedge i_clock);
        check({31'h0, o_peripheral_disable_lock}, 32'h1);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        // locked writes complete but leave every register unchanged
        for (int n = 0; n < 4; n++) begin
            wr(pmd_lock_pkg::OFS_PMD_BASE + 16'(4 * n), 32'hffff_ffff);
            rd_chk(pmd_lock_pkg::OFS_PMD_BASE + 16'(4 * n), (n == 0) ? 32'ha5a5_0001 : 32'h0);
        end
        check(o_peripheral_disable_regs[63:32], 32'h0);
        // an unrelated write cancels the armed sequence
        unlock();
        wr(pmd_lock_pkg::OFS_PMD_BASE, 32'h0);
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        // clear the lock, then a store goes through
        unlock();
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        wr(pmd_lock_pkg::OFS_PMD_BASE + 16'h000c, 32'h1234_5678);
        rd_chk(pmd_lock_pkg::OFS_PMD_BASE + 16'h000c, 32'h1234_5678);
        // one-way mode: set once, never cleared
        i_config_word_three <= 32'h1 << pmd_lock_pkg::ONE_WAY_BIT;
        repeat (4) @(posedge i_clock);
        wr(pmd_lock_pkg::OFS_CONFIG_WORD_THREE, 32'h0);
        rd_chk(pmd_lock_pkg::OFS_CONFIG_WORD_THREE, 32'h1 << pmd_lock_pkg::ONE_WAY_BIT);
        unlock();
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        unlock();
        wr(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, 32'h0);
        rd_chk(pmd_lock_pkg::OFS_SYSTEM_CONFIG_CONTROL, lk);
        wr(pmd_lock_pkg::OFS_PMD_BASE + 16'h0008, 32'h0000_00ff);
        rd_chk(pmd_lock_pkg::OFS_PMD_BASE + 16'h0008, 32'h0);
        // only a reset frees the stuck lock
        do_reset();
        @(negedge i_clock);
        check({31'h0, o_peripheral_disable_lock}, 32'h0);
        check(o_peripheral_disable_regs[127:96], 32'h0);
        wr(pmd_lock_pkg::OFS_PMD_BASE + 16'h0008, 32'h0000_00ff);
        rd_chk(pmd_lock_pkg::OFS_PMD_BASE + 16'h0008, 32'h0000_00ff);
        check(o_peripheral_disable_regs[95:64], 32'h0000_00ff);
        stop_test();
    end

endmodule : tb_top
